// ==== hw/tsr_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants of the temperature sensor register file
// Assumes: Byte-level access delivered by a separate serial front end
// Notes:   Select codes, field positions, reset values and fault counts
//////////////////////////////////////////////////////////////////////////////
package tsr_pkg;

  // Select codes held in the low three bits of register_select
  localparam logic [2:0] SEL_TEMPERATURE_RESULT = 3'h0;
  localparam logic [2:0] SEL_OPERATING_CONFIG   = 3'h1;
  localparam logic [2:0] SEL_LOW_LIMIT          = 3'h2;
  localparam logic [2:0] SEL_HIGH_LIMIT         = 3'h3;
  localparam logic [2:0] SEL_SINGLE_CONVERSION  = 3'h4;

  // Reset values
  localparam logic [7:0]  REGISTER_SELECT_RESET    = 8'h00;
  localparam logic [15:0] TEMPERATURE_RESULT_RESET = 16'h0000;
  localparam logic [15:0] OPERATING_CONFIG_RESET   = 16'h0000;
  localparam logic [15:0] LOW_LIMIT_RESET          = 16'h4b00;
  localparam logic [15:0] HIGH_LIMIT_RESET         = 16'h5000;

  // Field layout of the select register and the 16-bit registers
  localparam int SELECT_BITS_MSB     = 2;
  localparam int VALUE_MSB           = 15;
  localparam int VALUE_LSB           = 4;
  localparam int SINGLE_CONV_POS     = 13;
  localparam int FAULT_QUEUE_MSB     = 12;
  localparam int FAULT_QUEUE_LSB     = 11;
  localparam int ALERT_POLARITY_POS  = 10;
  localparam int THERMOSTAT_MODE_POS = 9;
  localparam int SHUTDOWN_POS        = 8;

  // Consecutive faults needed per fault_queue_depth code
  localparam logic [2:0] FAULTS_CODE0 = 3'h1;
  localparam logic [2:0] FAULTS_CODE1 = 3'h2;
  localparam logic [2:0] FAULTS_CODE2 = 3'h4;
  localparam logic [2:0] FAULTS_CODE3 = 3'h6;

  typedef enum logic [1:0] {
    CONV_SHUTDOWN,
    CONV_CONTINUOUS,
    CONV_SINGLE
  } tsr_conv_state_type;

endpackage

// ==== hw/tsr_register_file.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Pointer-addressed register bank of a digital temperature sensor
// Assumes: Serial front end gives one-cycle byte strobes on clk
// Notes:   16-bit registers move MSB first; frameStart restarts byte order
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module tsr_register_file
  import tsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        frameStart,
  input  wire logic        selectWrite,
  input  wire logic        dataWrite,
  input  wire logic [7:0]  writeByte,
  input  wire logic        readByte,
  input  wire logic        convDone,
  input  wire logic [11:0] convResult,
  output logic      [7:0]  readData,
  output logic             readValid,
  output logic             convRunning,
  output logic             singleConvStart,
  output logic      [2:0]  faultsNeeded,
  output logic             alertPolarity,
  output logic             thermostatMode,
  output logic             shutdownActive,
  output logic      [11:0] lowLimit,
  output logic      [11:0] highLimit
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  registerSelect_reg;
  logic        byteIndex_reg;
  logic [11:0] temperatureResult_reg;
  logic        singleConversionBit_reg;
  logic [1:0]  faultQueueDepth_reg;
  logic        alertPolarity_reg;
  logic        thermostatMode_reg;
  logic        shutdownBit_reg;
  logic [11:0] lowLimit_reg;
  logic [11:0] highLimit_reg;
  logic [7:0]  readData_reg;
  logic        readValid_reg;
  logic        singleConvStart_reg;
  logic [2:0]  faultsNeeded_reg;
  logic        convRunning_reg;
  tsr_conv_state_type convState_reg;
  tsr_conv_state_type convState_next;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [2:0]  selectCode;
  logic        msbPhase;
  logic        writeConfig;
  logic        writeLow;
  logic        writeHigh;
  logic        writeTrigger;
  logic        writeConfigMsb;
  logic        writeLowMsb;
  logic        writeLowLsb;
  logic        writeHighMsb;
  logic        writeHighLsb;
  logic [15:0] configWord;
  logic [15:0] resultWord;
  logic [15:0] lowWord;
  logic [15:0] highWord;
  logic [15:0] selectedWord;
  logic [7:0]  selectedByte;
  logic        triggerAccepted;
  logic        storeResult;
  logic [2:0]  faultsNeededNext;
  logic [7:0]  selectNext;
  logic        byteIndexNext;

  assign selectCode   = registerSelect_reg[SELECT_BITS_MSB:0];
  assign msbPhase     = ~byteIndex_reg;
  assign writeConfig  = dataWrite && (selectCode == SEL_OPERATING_CONFIG);
  assign writeLow     = dataWrite && (selectCode == SEL_LOW_LIMIT);
  assign writeHigh    = dataWrite && (selectCode == SEL_HIGH_LIMIT);
  assign writeTrigger = dataWrite && (selectCode == SEL_SINGLE_CONVERSION);

  // Byte position splits each data write into its MS or LS half
  assign writeConfigMsb = writeConfig && msbPhase;
  assign writeLowMsb    = writeLow && msbPhase;
  assign writeLowLsb    = writeLow && !msbPhase;
  assign writeHighMsb   = writeHigh && msbPhase;
  assign writeHighLsb   = writeHigh && !msbPhase;

  // Reserved configuration bits and the whole low byte read zero
  assign configWord = {2'h0, singleConversionBit_reg, faultQueueDepth_reg,
                       alertPolarity_reg, thermostatMode_reg, shutdownBit_reg,
                       8'h00};
  assign resultWord = {temperatureResult_reg, 4'h0};
  assign lowWord    = {lowLimit_reg, 4'h0};
  assign highWord   = {highLimit_reg, 4'h0};

  // Trigger and unused codes read as zero
  assign selectedWord =
    (selectCode == SEL_TEMPERATURE_RESULT) ? resultWord :
    (selectCode == SEL_OPERATING_CONFIG)   ? configWord :
    (selectCode == SEL_LOW_LIMIT)          ? lowWord    :
    (selectCode == SEL_HIGH_LIMIT)         ? highWord   : 16'h0000;

  assign selectedByte = msbPhase ? selectedWord[15:8] : selectedWord[7:0];

  // Pointer byte keeps only the select bits; reserved bits stay zero
  assign selectNext = selectWrite ? {5'h00, writeByte[SELECT_BITS_MSB:0]}
                                  : registerSelect_reg;

  // Any new frame or pointer write restarts at the MS byte
  assign byteIndexNext = (frameStart || selectWrite) ? 1'b0 :
                         (readByte || dataWrite)     ? ~byteIndex_reg :
                                                       byteIndex_reg;

  // A trigger during a running single conversion is dropped, not queued
  assign triggerAccepted = writeTrigger && !shutdownBit_reg &&
                           singleConversionBit_reg;

  // Result only follows conversions the mode allows
  assign storeResult = convDone && (convState_reg != CONV_SHUTDOWN);

  assign faultsNeededNext =
    (faultQueueDepth_reg == 2'h0) ? FAULTS_CODE0 :
    (faultQueueDepth_reg == 2'h1) ? FAULTS_CODE1 :
    (faultQueueDepth_reg == 2'h2) ? FAULTS_CODE2 : FAULTS_CODE3;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion mode

  always_comb
  begin
    convState_next = convState_reg;
    unique case (convState_reg)
      CONV_SHUTDOWN:
      begin
        if (!shutdownBit_reg && !singleConversionBit_reg)
          convState_next = CONV_CONTINUOUS;
        else if (triggerAccepted)
          convState_next = CONV_SINGLE;
      end
      CONV_CONTINUOUS:
      begin
        if (shutdownBit_reg || singleConversionBit_reg)
          convState_next = CONV_SHUTDOWN;
      end
      CONV_SINGLE:
      begin
        // Setting shutdown aborts a running single conversion
        if (shutdownBit_reg || convDone)
          convState_next = CONV_SHUTDOWN;
      end
      // Unused state code falls back to the safe idle state
      default:
        convState_next = CONV_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      convState_reg       <= CONV_CONTINUOUS;
      convRunning_reg     <= 1'b1;
      singleConvStart_reg <= 1'b0;
    end
    else
    begin
      convState_reg       <= convState_next;
      convRunning_reg     <= (convState_next != CONV_SHUTDOWN);
      singleConvStart_reg <= triggerAccepted && (convState_reg == CONV_SHUTDOWN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Select register and byte order

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      registerSelect_reg <= REGISTER_SELECT_RESET;
      byteIndex_reg      <= 1'b0;
    end
    else
    begin
      registerSelect_reg <= selectNext;
      byteIndex_reg      <= byteIndexNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature result

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      temperatureResult_reg <= TEMPERATURE_RESULT_RESET[VALUE_MSB:VALUE_LSB];
    else if (storeResult)
      temperatureResult_reg <= convResult;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration: only the MS byte holds fields, so LS byte writes drop out

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      singleConversionBit_reg <= OPERATING_CONFIG_RESET[SINGLE_CONV_POS];
      faultQueueDepth_reg     <= OPERATING_CONFIG_RESET[FAULT_QUEUE_MSB:FAULT_QUEUE_LSB];
      alertPolarity_reg       <= OPERATING_CONFIG_RESET[ALERT_POLARITY_POS];
      thermostatMode_reg      <= OPERATING_CONFIG_RESET[THERMOSTAT_MODE_POS];
      shutdownBit_reg         <= OPERATING_CONFIG_RESET[SHUTDOWN_POS];
    end
    else if (writeConfigMsb)
    begin
      singleConversionBit_reg <= writeByte[SINGLE_CONV_POS - 8];
      faultQueueDepth_reg     <= writeByte[FAULT_QUEUE_MSB - 8:FAULT_QUEUE_LSB - 8];
      alertPolarity_reg       <= writeByte[ALERT_POLARITY_POS - 8];
      thermostatMode_reg      <= writeByte[THERMOSTAT_MODE_POS - 8];
      shutdownBit_reg         <= writeByte[SHUTDOWN_POS - 8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Limits: MS and LS bytes both update their halves, low nibble never stored

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lowLimit_reg  <= LOW_LIMIT_RESET[VALUE_MSB:VALUE_LSB];
      highLimit_reg <= HIGH_LIMIT_RESET[VALUE_MSB:VALUE_LSB];
    end
    else
    begin
      if (writeLowMsb)
        lowLimit_reg[11:4] <= writeByte;
      else if (writeLowLsb)
        lowLimit_reg[3:0] <= writeByte[7:4];
      if (writeHighMsb)
        highLimit_reg[11:4] <= writeByte;
      else if (writeHighLsb)
        highLimit_reg[3:0] <= writeByte[7:4];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path and registered copies of the controls

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readData_reg     <= 8'h00;
      readValid_reg    <= 1'b0;
      faultsNeeded_reg <= FAULTS_CODE0;
    end
    else
    begin
      readValid_reg    <= readByte;
      faultsNeeded_reg <= faultsNeededNext;
      // Byte holds between reads so a slow front end can still take it
      if (readByte)
        readData_reg <= selectedByte;
    end
  end

  assign readData        = readData_reg;
  assign readValid       = readValid_reg;
  assign convRunning     = convRunning_reg;
  assign singleConvStart = singleConvStart_reg;
  assign faultsNeeded    = faultsNeeded_reg;
  assign alertPolarity   = alertPolarity_reg;
  assign thermostatMode  = thermostatMode_reg;
  assign shutdownActive  = shutdownBit_reg;
  assign lowLimit        = lowLimit_reg;
  assign highLimit       = highLimit_reg;

endmodule

// ==== verification/tsr_register_file_props.sv ====
// Purpose: Port checks of the sensor register file
// Assumes: One clock, async active-high reset
// Notes:   Bound to every instance at the foot of this file
////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module tsr_register_file_props (
  input logic        clk,
  input logic        sys_rst,
  input logic        frameStart,
  input logic        selectWrite,
  input logic        dataWrite,
  input logic [7:0]  writeByte,
  input logic        readByte,
  input logic        convDone,
  input logic [11:0] convResult,
  input logic [7:0]  readData,
  input logic        readValid,
  input logic        convRunning,
  input logic        singleConvStart,
  input logic [2:0]  faultsNeeded,
  input logic        alertPolarity,
  input logic        thermostatMode,
  input logic        shutdownActive,
  input logic [11:0] lowLimit,
  input logic [11:0] highLimit
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence startSeq;
    singleConvStart ##0 convRunning;
  endsequence
  sequence quietSeq;
    !singleConvStart;
  endsequence
  read_valid_a: assert property (readValid == $past(readByte))
    else $error("read answer not one cycle after request");
  read_hold_a: assert property (!readByte |=> $stable(readData))
    else $error("read byte moved without request");
  fault_code_a: assert property (faultsNeeded inside {3'h1, 3'h2, 3'h4, 3'h6})
    else $error("fault count outside its table");
  shut_idle_a: assert property (shutdownActive |-> quietSeq)
    else $error("conversion started while shut down");
  shut_stop_a: assert property ($rose(shutdownActive) |=> !convRunning)
    else $error("conversion kept running after shutdown");
  start_runs_a: assert property (singleConvStart |-> startSeq)
    else $error("single start without running conversion");
  start_pulse_a: assert property (singleConvStart |=> quietSeq)
    else $error("single start longer than one cycle");
  limit_hold_a: assert property (!dataWrite |=> $stable(lowLimit) && $stable(highLimit))
    else $error("limit changed without data write");
  cfg_hold_a: assert property (!dataWrite |=>
    $stable({alertPolarity, thermostatMode, shutdownActive}))
    else $error("configuration changed without data write");
endmodule
bind tsr_register_file tsr_register_file_props chk (.*);

// ==== verification/tsr_host_model.sv ====
// Purpose: Serial host front end seen as byte strobes
// Assumes: Strobes change 1 ns after a rising edge
// Notes:   Idle write byte is the inverse of the last one
////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module tsr_host_model (
  input  logic       clk,
  input  logic [7:0] readData,
  input  logic       readValid,
  output logic       frameStart,
  output logic       selectWrite,
  output logic       dataWrite,
  output logic [7:0] writeByte,
  output logic       readByte
);
  initial
  begin
    {frameStart, selectWrite, dataWrite, readByte} = 4'h0;
    writeByte = 8'h00;
  end
  // Held until the next edge takes it; a later put replaces it
  task automatic put(input logic [3:0] s, input logic [7:0] b);
    @(posedge clk);
    #1;
    {frameStart, selectWrite, dataWrite, readByte} = s;
    writeByte = b;
  endtask
  task automatic wr16(input logic [7:0] sel, input logic [7:0] hi, input logic [7:0] lo);
    logic cfg;
    cfg = sel[2:0] == 3'h1;
    put(4'h8, 8'h00);
    put(4'h4, sel);
    put(4'h2, cfg ? hi & 8'h3f : hi);
    put(4'h2, cfg ? 8'h00 : lo);
    put(4'h0, ~writeByte);
  endtask
  task automatic wr8(input logic [7:0] sel, input logic [7:0] b);
    put(4'h4, sel);
    put(4'h2, b);
    put(4'h0, ~b);
  endtask
  task automatic rd16(input logic [7:0] sel, output logic [15:0] v, output logic [1:0] ok);
    put(4'h4, sel);
    put(4'h1, ~sel);
    put(4'h1, sel);
    v[15:8] = readData;
    ok[1] = readValid;
    put(4'h0, ~sel);
    v[7:0] = readData;
    ok[0] = readValid;
  endtask
endmodule

// ==== verification/tsr_register_file_test.sv ====
// Purpose: Self-checking bench of the sensor register file
// Assumes: Host model owns the strobes; bench drives conversions
// Notes:   Expected values come from a register array model
////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module tsr_register_file_test;
  import tsr_pkg::*;
  logic        clk = 0, sys_rst = 1, convDone = 0;
  logic [11:0] convResult = 12'h000, lowLimit, highLimit;
  logic        frameStart, selectWrite, dataWrite, readByte, readValid;
  logic        convRunning, singleConvStart, alertPolarity, thermostatMode, shutdownActive;
  logic [7:0]  writeByte, readData;
  logic [2:0]  faultsNeeded;
  logic [31:0] rnd = 32'h7df0;
  logic [15:0] expReg[8];
  int          badCount, checks;
  tsr_register_file dut (.*);
  tsr_host_model host (.*);
  initial
    forever #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict;
    $display("checks=%0d mismatches=%0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic conv(input logic keep);
    rnd = lfsr(rnd);
    @(posedge clk);
    #1;
    convDone = 1;
    convResult = rnd[11:0];
    @(posedge clk);
    #1;
    convDone = 0;
    convResult = ~rnd[11:0];
    if (keep)
      expReg[0] = {rnd[11:0], 4'h0};
  endtask
  task automatic wr(input int c, input logic [7:0] hi, input logic [7:0] lo);
    rnd = lfsr(rnd);
    host.wr16({rnd[4:0], c[2:0]}, hi, lo);
    if (c == 1)
      expReg[1] = {hi & 8'h3f, 8'h00};
    else if (c == 2 || c == 3)
      expReg[c] = {hi, lo & 8'hf0};
  endtask
  task automatic readAll;
    logic [15:0] v;
    logic [1:0]  ok;
    for (int c = 0; c < 8; c++)
    begin
      rnd = lfsr(rnd);
      host.rd16({rnd[4:0], c[2:0]}, v, ok);
      chk(v, expReg[c]);
      chk(16'(ok), 16'h3);
    end
  endtask
  task automatic chkCfg;
    logic [15:0] fq[4] = '{16'h1, 16'h2, 16'h4, 16'h6};
    repeat (2) @(posedge clk);
    #1;
    chk(16'(faultsNeeded), fq[expReg[1][12:11]]);
    chk(16'({alertPolarity, thermostatMode, shutdownActive}), 16'(expReg[1][10:8]));
    chk(16'(lowLimit), 16'(expReg[2][15:4]));
    chk(16'(highLimit), 16'(expReg[3][15:4]));
  endtask
  initial
  begin
    expReg = '{16'h0, 16'h0, LOW_LIMIT_RESET, HIGH_LIMIT_RESET, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 0;
    chk(16'(convRunning), 16'h1);
    chkCfg;
    readAll;
    conv(1);
    readAll;
    for (int r = 0; r < 6; r++)
    begin
      for (int c = 0; c < 8; c++)
        if (c != 4)
          wr(c, rnd[23:16], rnd[7:0]);
      chkCfg;
      readAll;
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(1, {3'h0, k[1:0], k[0], k[1], 1'b0}, 8'h00);
      chkCfg;
    end
    // MSB-only update, then a new frame restarts at MSB
    host.put(4'h4, 8'h02);
    host.put(4'h2, 8'h7a);
    host.put(4'h8, 8'h00);
    host.put(4'h2, 8'h61);
    host.put(4'h0, 8'h9e);
    expReg[2][15:8] = 8'h61;
    readAll;
    wr(1, 8'h20, 8'h00);
    chkCfg;
    chk(16'(convRunning), 16'h0);
    host.wr8({5'h1f, SEL_SINGLE_CONVERSION}, 8'h5a);
    chk(16'({singleConvStart, convRunning}), 16'h3);
    conv(1);
    chk(16'(convRunning), 16'h0);
    wr(1, 8'h21, 8'h00);
    chkCfg;
    host.wr8({5'h00, SEL_SINGLE_CONVERSION}, 8'ha5);
    chk(16'({singleConvStart, convRunning}), 16'h0);
    conv(0);
    readAll;
    wr(1, 8'h00, 8'h00);
    chkCfg;
    chk(16'(convRunning), 16'h1);
    conv(1);
    readAll;
    giveVerdict;
  end
  // Run needs under 2000 cycles; this allows five times that
  initial
  begin
    #100000;
    badCount++;
    giveVerdict;
  end
endmodule
